// *** design/mic_input_fault_latch_status.sv ***
// latched input fault status registers of analog channels 2 to 4, on apb
//
// The APB slave port was chosen for this implementation.
module mic_input_fault_latch_status
	import fault_latch_pkg::*;
(
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST,
	// apb slave
	input wire apb_req_t APB_REQ,
	output logic PREADY,
	output logic [APB_DATA_W-1:0] PRDATA,
	output logic PSLVERR,
	// fault detector events, one per channel
	input wire fault_event_t FAULT_CH2,
	input wire fault_event_t FAULT_CH3,
	input wire fault_event_t FAULT_CH4,
	// overvoltage latch register kept elsewhere
	input wire logic [LATCH_W-1:0] NEG_OV_LATCH_VALUE,
	output logic NEG_OV_LATCH_READ,
	// per channel latched status, ch2 in bit 0
	output logic [NUM_CH-1:0] FAULT_PENDING
);

	// =====================================================================
	// declarations
	// =====================================================================
	fault_event_t fault_in [NUM_CH];
	logic [LATCH_W-1:0] set_vec [NUM_CH];
	logic [LATCH_W-1:0] clear_vec [NUM_CH];
	logic [LATCH_W-1:0] latch [NUM_CH];
	target_t target;
	logic access;
	logic read_done;
	logic clear_low;
	logic [NUM_CH-1:0] clear_own;
	logic [APB_DATA_W-1:0] next_prdata;
	logic next_pslverr;

	// =====================================================================
	// channel inputs
	// =====================================================================
	always_comb
	begin
		fault_in[0] = FAULT_CH2;
		fault_in[1] = FAULT_CH3;
		fault_in[2] = FAULT_CH4;
	end

	// =====================================================================
	// address decode
	// =====================================================================
	fault_latch_decode u_decode
	(
		.paddr(APB_REQ.paddr),
		.target(target)
	);

	// =====================================================================
	// apb handshake
	// =====================================================================
	// one wait state: pready rises the edge after the access phase opens,
	// so the answer is always a flop and never a path through the decode
	always_comb
	begin
		access = APB_REQ.psel & APB_REQ.penable & ~PREADY;
		read_done = access & ~APB_REQ.pwrite;
	end

	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			PREADY <= 1'b0;
		end
		else
		begin
			PREADY <= access;
		end
	end

	// =====================================================================
	// clear strobes
	// =====================================================================
	// the clear lands on the edge the read data is captured, so for a channel read
	// the value returned and the value wiped are the same snapshot; a read of the
	// overvoltage register returns NEG_OV_LATCH_VALUE and wipes bit 0 of every channel
	always_comb
	begin
		clear_own[0] = read_done && (target == TGT_CH2);
		clear_own[1] = read_done && (target == TGT_CH3);
		clear_own[2] = read_done && (target == TGT_CH4);
		clear_low = read_done && (target == TGT_NEG_OV);
	end

	// =====================================================================
	// fault latches
	// =====================================================================
	generate
		for (genvar c = 0; c < NUM_CH; c++)
		begin : g_ch
			always_comb
			begin
				set_vec[c][BIT_OPEN_INPUT] = fault_in[c].open_input;
				set_vec[c][BIT_PAIR_SHORT] = fault_in[c].pair_short;
				set_vec[c][BIT_POS_GND] = fault_in[c].pos_to_ground;
				set_vec[c][BIT_NEG_GND] = fault_in[c].neg_to_ground;
				set_vec[c][BIT_POS_BIAS] = fault_in[c].pos_to_mic_bias_supply;
				set_vec[c][BIT_NEG_BIAS] = fault_in[c].neg_to_mic_bias_supply;
				set_vec[c][BIT_POS_BATT] = fault_in[c].pos_to_battery;
				set_vec[c][BIT_NEG_BATT] = fault_in[c].neg_to_battery;
			end

			always_comb
			begin
				clear_vec[c] = ({LATCH_W{clear_own[c]}} & SELF_CLEAR_MASK)
					| ({LATCH_W{clear_low}} & OV_CLEAR_MASK);
			end

			// reset to LATCH_RESET for all three channels
			fault_latch_cell #(
				.WIDTH(LATCH_W)
			) u_cell
			(
				.clk(CLK_SYS),
				.rst(RST),
				.set_vec(set_vec[c]),
				.clear_vec(clear_vec[c]),
				.latch(latch[c])
			);
		end
	endgenerate

	// =====================================================================
	// read data
	// =====================================================================
	// writes to the read-only latches are accepted and dropped;
	// only an address outside the map answers with an error
	always_comb
	begin
		next_prdata = RDATA_RESET;
		next_pslverr = 1'b0;
		case (target)
			TGT_CH2:
			begin
				next_prdata[LATCH_W-1:0] = latch[0];
			end
			TGT_CH3:
			begin
				next_prdata[LATCH_W-1:0] = latch[1];
			end
			TGT_CH4:
			begin
				next_prdata[LATCH_W-1:0] = latch[2];
			end
			TGT_NEG_OV:
			begin
				next_prdata[LATCH_W-1:0] = NEG_OV_LATCH_VALUE;
			end
			default:
			begin
				next_pslverr = 1'b1;
			end
		endcase
		if (APB_REQ.pwrite)
		begin
			next_prdata = RDATA_RESET;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			PRDATA <= RDATA_RESET;
		end
		else if (access)
		begin
			PRDATA <= next_prdata;
		end
		else if (PREADY)
		begin
			PRDATA <= RDATA_RESET;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			PSLVERR <= 1'b0;
		end
		else
		begin
			PSLVERR <= access & next_pslverr;
		end
	end

	// =====================================================================
	// side effects seen outside
	// =====================================================================
	// the overvoltage register itself clears on this pulse
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			NEG_OV_LATCH_READ <= 1'b0;
		end
		else
		begin
			NEG_OV_LATCH_READ <= clear_low;
		end
	end

	// one cycle behind the latch; the interrupt combiner masks it elsewhere
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			FAULT_PENDING <= '0;
		end
		else
		begin
			for (int c = 0; c < NUM_CH; c++)
			begin
				FAULT_PENDING[c] <= |latch[c];
			end
		end
	end

endmodule : mic_input_fault_latch_status

// *** design/fault_latch_pkg.sv ***
// package: register map, field layout and carrier types of the input fault latch bank
package fault_latch_pkg;

	// =====================================================================
	// bus geometry
	// =====================================================================
	localparam int APB_ADDR_W = 12;
	localparam int APB_DATA_W = 32;
	localparam int LATCH_W = 8;
	localparam int NUM_CH = 3;
	localparam int WORD_LSB = 2;

	// =====================================================================
	// register indices; byte address is four times the index
	// =====================================================================
	localparam logic [7:0] CH2_LATCH_INDEX = 8'h2f;
	localparam logic [7:0] CH3_LATCH_INDEX = 8'h30;
	localparam logic [7:0] CH4_LATCH_INDEX = 8'h31;
	localparam logic [7:0] NEG_OV_LATCH_INDEX = 8'h36;

	// =====================================================================
	// reset values
	// =====================================================================
	localparam logic [LATCH_W-1:0] LATCH_RESET = 8'h00;
	localparam logic [APB_DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

	// =====================================================================
	// field positions inside one latch register
	// =====================================================================
	localparam int BIT_OPEN_INPUT = 7;
	localparam int BIT_PAIR_SHORT = 6;
	localparam int BIT_POS_GND = 5;
	localparam int BIT_NEG_GND = 4;
	localparam int BIT_POS_BIAS = 3;
	localparam int BIT_NEG_BIAS = 2;
	localparam int BIT_POS_BATT = 1;
	localparam int BIT_NEG_BATT = 0;

	// bits 7..1 clear on reading their own register, bit 0 does not
	localparam logic [LATCH_W-1:0] SELF_CLEAR_MASK = 8'hfe;
	localparam logic [LATCH_W-1:0] OV_CLEAR_MASK = 8'h01;

	// =====================================================================
	// carriers
	// =====================================================================
	typedef struct packed {
		logic open_input;
		logic pair_short;
		logic pos_to_ground;
		logic neg_to_ground;
		logic pos_to_mic_bias_supply;
		logic neg_to_mic_bias_supply;
		logic pos_to_battery;
		logic neg_to_battery;
	} fault_event_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [APB_ADDR_W-1:0] paddr;
		logic [APB_DATA_W-1:0] pwdata;
	} apb_req_t;

	typedef enum {
		TGT_CH2,
		TGT_CH3,
		TGT_CH4,
		TGT_NEG_OV,
		TGT_NONE
	} target_t;

endpackage : fault_latch_pkg

// *** design/fault_latch_cell.sv ***
// one channel's eight sticky fault bits with read-clear
module fault_latch_cell
	import fault_latch_pkg::*;
#(
	parameter int WIDTH = LATCH_W
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// fault events and clears
	input wire logic [WIDTH-1:0] set_vec,
	input wire logic [WIDTH-1:0] clear_vec,
	// latched state
	output logic [WIDTH-1:0] latch
);

	// =====================================================================
	// sticky bits
	// =====================================================================
	// set is or-ed in after the clear so an event on the clearing edge survives
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			latch <= LATCH_RESET[WIDTH-1:0];
		end
		else
		begin
			latch <= (latch & ~clear_vec) | set_vec;
		end
	end

endmodule : fault_latch_cell

// *** design/fault_latch_decode.sv ***
// address decode of the latch bank
module fault_latch_decode
	import fault_latch_pkg::*;
(
	// request address
	input wire logic [APB_ADDR_W-1:0] paddr,
	// decoded target
	output target_t target
);

	// =====================================================================
	// decode
	// =====================================================================
	function automatic target_t decode_index(input logic [APB_ADDR_W-1:0] addr);
		target_t t;
		t = TGT_NONE;
		if (addr[WORD_LSB-1:0] == 2'h0 && addr[APB_ADDR_W-1:WORD_LSB+8] == '0)
		begin
			case (addr[WORD_LSB+7:WORD_LSB])
				CH2_LATCH_INDEX: t = TGT_CH2;
				CH3_LATCH_INDEX: t = TGT_CH3;
				CH4_LATCH_INDEX: t = TGT_CH4;
				NEG_OV_LATCH_INDEX: t = TGT_NEG_OV;
				default: t = TGT_NONE;
			endcase
		end
		return t;
	endfunction : decode_index

	always_comb
	begin
		target = decode_index(paddr);
	end

endmodule : fault_latch_decode

// *** bench/fault_latch_props.sv ***
// checker: apb timing and latch status properties of the fault latch bank
module fault_latch_props
	import fault_latch_pkg::*;
(
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST,
	// watched ports
	input wire apb_req_t APB_REQ,
	input wire logic PREADY,
	input wire logic [APB_DATA_W-1:0] PRDATA,
	input wire logic PSLVERR,
	input wire fault_event_t FAULT_CH2,
	input wire logic [LATCH_W-1:0] NEG_OV_LATCH_VALUE,
	input wire logic NEG_OV_LATCH_READ,
	input wire logic [NUM_CH-1:0] FAULT_PENDING
);
	// =====================================================
	// properties
	// =====================================================
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	logic take;
	assign take = APB_REQ.psel && APB_REQ.penable && !PREADY;
	a_one_wait: assert property (take |=> PREADY && $past(APB_REQ.psel))
		else $error("ready late");
	a_ready_pulse: assert property (PREADY |=> !PREADY)
		else $error("ready held");
	a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0000_0000)
		else $error("rdata not zero");
	a_upper_zero: assert property (PREADY |-> PRDATA[31:8] == 24'h00_0000)
		else $error("upper bits set");
	a_misalign_err: assert property (take && APB_REQ.paddr[1:0] != 2'h0 |=> PSLVERR)
		else $error("no error");
	a_mapped_ok: assert property (take && APB_REQ.paddr == 12'h0c0 |=> !PSLVERR)
		else $error("mapped error");
	a_ov_read: assert property (take && !APB_REQ.pwrite && APB_REQ.paddr == 12'h0d8
		|=> NEG_OV_LATCH_READ && PRDATA[7:0] == $past(NEG_OV_LATCH_VALUE))
		else $error("ov read");
	a_ov_cause: assert property ($rose(NEG_OV_LATCH_READ) |-> $past(APB_REQ.paddr) == 12'h0d8)
		else $error("stray ov read");
	a_pending_ch2: assert property (FAULT_CH2 != 8'h00 |-> ##2 FAULT_PENDING[0])
		else $error("pending missed");
endmodule : fault_latch_props

bind mic_input_fault_latch_status fault_latch_props u_props (
	.CLK_SYS(CLK_SYS),
	.RST(RST),
	.APB_REQ(APB_REQ),
	.PREADY(PREADY),
	.PRDATA(PRDATA),
	.PSLVERR(PSLVERR),
	.FAULT_CH2(FAULT_CH2),
	.NEG_OV_LATCH_VALUE(NEG_OV_LATCH_VALUE),
	.NEG_OV_LATCH_READ(NEG_OV_LATCH_READ),
	.FAULT_PENDING(FAULT_PENDING)
);

// *** bench/mic_input_fault_latch_status_bench.sv ***
// testbench: register reads, clears and errors of the fault latch bank
module mic_input_fault_latch_status_bench
	import fault_latch_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic CLK_SYS = 1'b0;
	logic RST = 1'b1;
	apb_req_t req = '0;
	logic PREADY;
	logic [APB_DATA_W-1:0] PRDATA;
	logic PSLVERR;
	logic NEG_OV_LATCH_READ;
	logic [NUM_CH-1:0] FAULT_PENDING;
	fault_event_t flt [NUM_CH] = '{default: '0};
	logic [APB_DATA_W-1:0] d;
	logic e;
	logic [APB_ADDR_W-1:0] adr [NUM_CH] = '{12'h0bc, 12'h0c0, 12'h0c4};
	int miscompares = 0;
	int cmp_count = 0;
	always #2 CLK_SYS = ~CLK_SYS;
	mic_input_fault_latch_status uut (
		.CLK_SYS(CLK_SYS),
		.RST(RST),
		.APB_REQ(req),
		.PREADY(PREADY),
		.PRDATA(PRDATA),
		.PSLVERR(PSLVERR),
		.FAULT_CH2(flt[0]),
		.FAULT_CH3(flt[1]),
		.FAULT_CH4(flt[2]),
		.NEG_OV_LATCH_VALUE(8'h5a),
		.NEG_OV_LATCH_READ(NEG_OV_LATCH_READ),
		.FAULT_PENDING(FAULT_PENDING)
	);
	// =====================================================
	// tasks
	// =====================================================
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// request held until pready is seen high at a rising edge; data taken at that edge
	task xfer(input logic wr, input logic [APB_ADDR_W-1:0] a);
		@(posedge CLK_SYS);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: 32'h0000_00ff};
		@(posedge CLK_SYS);
		req.penable <= 1'b1;
		do
			@(posedge CLK_SYS);
		while (PREADY !== 1'b1);
		d = PRDATA;
		e = PSLVERR;
		req <= '0;
	endtask : xfer
	task pulse(input int c, input logic [7:0] v);
		@(posedge CLK_SYS);
		flt[c] <= v;
		@(posedge CLK_SYS);
		flt[c] <= 8'h00;
		repeat (2) @(negedge CLK_SYS);
	endtask : pulse
	task complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run
	// =====================================================
	// tests
	// =====================================================
	initial
	begin
		repeat (20000) @(posedge CLK_SYS);
		miscompares++;
		complete_run();
	end
	initial
	begin
		repeat (16) @(posedge CLK_SYS);
		RST <= 1'b0;
		for (int c = 0; c < NUM_CH; c++)
		begin
			xfer(1'b0, adr[c]);
			chk(d, 32'h0000_0000);
		end
		pulse(1, 8'h80);
		xfer(1'b1, 12'h0c0);
		chk(e, 1'b0);
		xfer(1'b0, 12'h0c0);
		chk(d, 32'h0000_0080);
		xfer(1'b0, 12'h0c1);
		chk(d, 32'h0000_0000);
		chk(e, 1'b1);
		xfer(1'b0, 12'h0d4);
		chk(e, 1'b1);
		// fault seen only in the access cycle, i.e. on the clearing edge itself
		fork
			xfer(1'b0, 12'h0c0);
			begin
				repeat (2) @(posedge CLK_SYS);
				flt[1] <= 8'h80;
				@(posedge CLK_SYS);
				flt[1] <= 8'h00;
			end
		join
		chk(d, 32'h0000_0000);
		xfer(1'b0, 12'h0c0);
		chk(d, 32'h0000_0080);
		xfer(1'b0, 12'h0c0);
		chk(d, 32'h0000_0000);
		for (int b = 0; b < LATCH_W; b++)
			for (int c = 0; c < NUM_CH; c++)
			begin
				pulse(c, 8'h01 << b);
				chk(FAULT_PENDING, 3'b001 << c);
				xfer(1'b0, adr[c]);
				chk(d, 32'h1 << b);
				xfer(1'b0, adr[c]);
				chk(d, (b == 0) ? 32'h1 : 32'h0);
				xfer(1'b0, 12'h0d8);
				chk(d, 32'h0000_005a);
				xfer(1'b0, adr[c]);
				chk(d, 32'h0000_0000);
			end
		complete_run();
	end
endmodule : mic_input_fault_latch_status_bench
